// ===== design/aisc_params.svh
// Constants for the analog input sampling control block
`ifndef AISC_PARAMS_SVH
`define AISC_PARAMS_SVH
`define AISC_CLK_MHZ 200
`define AISC_FILT_NS 1000
`define AISC_FILT_CYC ((`AISC_FILT_NS * `AISC_CLK_MHZ + 999) / 1000)
`define AISC_CONV_NS 10000
`define AISC_CONV_CYC ((`AISC_CONV_NS * `AISC_CLK_MHZ + 999) / 1000)
`define AISC_BUF_DEPTH 1024
`define AISC_OFF_CTRL 8'h00
`define AISC_OFF_CMD 8'h04
`define AISC_OFF_INTERVAL 8'h08
`define AISC_OFF_COUNT 8'h0c
`define AISC_OFF_CHAN 8'h10
`define AISC_OFF_STATUS 8'h14
`define AISC_OFF_DATA 8'h18
`define AISC_OFF_INT_STAT 8'h1c
`define AISC_OFF_INT_EN 8'h20
`define AISC_OFF_INT_CLR 8'h24
`define AISC_CTRL_START_SRC 0
`define AISC_CTRL_STOP_LO 1
`define AISC_CTRL_PACE 3
`define AISC_CTRL_POL_LO 4
`define AISC_CTRL_FILT_LO 7
`define AISC_CMD_START 0
`define AISC_CMD_STOP 1
`define AISC_CMD_CLEAR 2
`define AISC_INT_START 0
`define AISC_INT_END 1
`define AISC_INT_OVR 2
`define AISC_INT_PACE 3
`define AISC_STOP_COUNT 2'h0
`define AISC_STOP_EXT 2'h1
`define AISC_STOP_SW 2'h2
`endif

// ===== design/aisc_pkg.sv
// Types of the analog input sampling control block
`include "aisc_params.svh"
package aisc_pkg;
    typedef enum logic [1:0] {
        AISC_IDLE = 2'h0,
        AISC_ARMED = 2'h1,
        AISC_RUN = 2'h3
    } aisc_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } aisc_bus_t;

    typedef struct packed {
        logic start;
        logic [3:0] chan;
    } aisc_conv_req_t;

    typedef struct packed {
        logic done;
        logic [15:0] data;
    } aisc_conv_res_t;

    typedef struct packed {
        aisc_state_t fsm;
        logic [9:0] ctrl;
        logic [31:0] interval;
        logic [31:0] count_lim;
        logic [31:0] samples;
        logic [31:0] timer;
        logic [3:0] last_chan;
        logic [3:0] chan;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] filt;
        logic [2:0] prev;
        logic [2:0][7:0] fcnt;
        logic [10:0] space;
        logic scan;
        logic wait_done;
        logic [3:0] int_stat;
        logic [3:0] int_en;
        logic [1023:0][15:0] mem;
        logic [9:0] wr_ptr;
        logic [9:0] rd_ptr;
        logic [10:0] level;
        logic [31:0] rdata;
        logic irq;
        aisc_conv_req_t conv;
    } aisc_regs_t;
endpackage

// ===== design/aisc_top.sv
// Sequencer, pacing, input conditioning and sample buffer for the analog input
//
// Strobed register access and the register offsets are this design's own decisions.
`include "aisc_params.svh"

//
// Overview of operation
// R1 - Start by software command or external edge
// R2 - Stop on count, external edge, or software
// R3 - Each external input picks rising or falling
// R4 - Optional one microsecond filter rejects short pulses
// R5 - Pace by interval timer or external clock
// R6 - Sixteen-bit result from one of sixteen channels
// R7 - Results stored in 1024-word local buffer
// R8 - Acquisition runs without host per sample
// R9 - Errors and events on one interrupt
// R10 - At least ten microseconds per channel
// R11 - Outside source drives start, stop, clock
// R12 - Full buffer flags overrun, keeps stored data
// R13 - Synchronize then detect single-cycle edges
module aisc_top (
    input wire logic mclk, // 200 MHz clock
    input wire logic rst, // Async reset, active high
    input wire aisc_pkg::aisc_bus_t bus, // Register request
    output logic [31:0] rdata, // Read data, cycle after read
    input wire aisc_pkg::aisc_conv_res_t res, // Converter result
    output aisc_pkg::aisc_conv_req_t conv, // Converter request
    input wire logic ext_start, // External start trigger pin
    input wire logic ext_stop, // External stop trigger pin
    input wire logic ext_clk, // External sampling clock pin
    output logic irq // Level interrupt request
);
    import aisc_pkg::*;

    localparam logic [7:0] FILT_LAST = 8'(`AISC_FILT_CYC - 1);
    localparam logic [10:0] SPACE_LAST = 11'(`AISC_CONV_CYC - 1);
    localparam logic [10:0] DEPTH = 11'(`AISC_BUF_DEPTH);

    aisc_regs_t st;
    aisc_regs_t next_st;
    logic [2:0] edge_evt;

    function automatic logic aisc_mapped(input logic [7:0] a);
        case (a)
            `AISC_OFF_CTRL, `AISC_OFF_INTERVAL, `AISC_OFF_COUNT, `AISC_OFF_CHAN,
            `AISC_OFF_STATUS, `AISC_OFF_DATA, `AISC_OFF_INT_STAT,
            `AISC_OFF_INT_EN: aisc_mapped = 1'b1;
            default: aisc_mapped = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Edge events on the filtered inputs
    for (genvar i = 0; i < 3; i++) begin : g_edge
        assign edge_evt[i] = st.ctrl[`AISC_CTRL_POL_LO + i] ? // R3
            (st.prev[i] & ~st.filt[i]) : (~st.prev[i] & st.filt[i]); // R13
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [3:0] ev;
        logic [3:0] clr;
        logic push;
        logic pop;
        logic pace;
        logic stop;
        logic [31:0] ival;
        ev = 4'h0;
        clr = 4'h0;
        push = 1'b0;
        pop = 1'b0;
        pace = 1'b0;
        stop = 1'b0;
        ival = (st.interval == 32'h0) ? 32'h1 : st.interval;
        next_st = st;
        next_st.conv.start = 1'b0;
        next_st.rdata = 32'h0;

        // Two-stage synchronizer, then optional filter
        next_st.sync1 = {ext_clk, ext_stop, ext_start}; // R13
        next_st.sync2 = st.sync1; // R13
        next_st.prev = st.filt;
        for (int i = 0; i < 3; i++) begin
            if (!st.ctrl[`AISC_CTRL_FILT_LO + i]) begin
                next_st.filt[i] = st.sync2[i];
                next_st.fcnt[i] = 8'h0;
            end else if (st.sync2[i] == st.filt[i]) begin
                next_st.fcnt[i] = 8'h0; // R4
            end else if (st.fcnt[i] == FILT_LAST) begin
                next_st.filt[i] = st.sync2[i]; // R4
                next_st.fcnt[i] = 8'h0;
            end else begin
                next_st.fcnt[i] = st.fcnt[i] + 8'h1;
            end
        end

        // Pacing source
        if (st.fsm == AISC_RUN) begin
            if (st.ctrl[`AISC_CTRL_PACE]) begin
                pace = edge_evt[2]; // R5
            end else if (st.timer >= ival - 32'h1) begin
                pace = 1'b1; // R5
                next_st.timer = 32'h0;
            end else begin
                next_st.timer = st.timer + 32'h1;
            end
        end
        if (pace) begin
            if (st.scan) begin
                ev[`AISC_INT_PACE] = 1'b1;
            end else begin
                next_st.scan = 1'b1;
                next_st.chan = 4'h0;
            end
        end

        // Channel scan with minimum spacing
        if (st.space != 11'h0) begin
            next_st.space = st.space - 11'h1;
        end
        if (st.scan && !st.wait_done && st.space == 11'h0) begin
            next_st.conv.start = 1'b1; // R8
            next_st.conv.chan = st.chan; // R6
            next_st.wait_done = 1'b1;
            next_st.space = SPACE_LAST; // R10
        end
        if (res.done && st.wait_done) begin
            next_st.wait_done = 1'b0;
            next_st.samples = st.samples + 32'h1;
            if (st.level == DEPTH) begin
                ev[`AISC_INT_OVR] = 1'b1; // R12
            end else begin
                push = 1'b1; // R7
            end
            if (st.chan == st.last_chan) begin
                next_st.scan = 1'b0;
            end else begin
                next_st.chan = st.chan + 4'h1;
            end
            if (st.ctrl[`AISC_CTRL_STOP_LO +: 2] == `AISC_STOP_COUNT
                    && st.samples + 32'h1 == st.count_lim) begin
                stop = 1'b1; // R2
            end
        end
        if (st.ctrl[`AISC_CTRL_STOP_LO +: 2] == `AISC_STOP_EXT && edge_evt[1]) begin
            stop = 1'b1; // R2
        end

        // Sequence control
        case (st.fsm)
            AISC_IDLE: begin
                if (bus.wr && bus.addr == `AISC_OFF_CMD && bus.wdata[`AISC_CMD_START]) begin
                    next_st.samples = 32'h0;
                    next_st.timer = 32'h0;
                    if (st.ctrl[`AISC_CTRL_START_SRC]) begin
                        next_st.fsm = AISC_ARMED;
                    end else begin
                        next_st.fsm = AISC_RUN; // R1
                        ev[`AISC_INT_START] = 1'b1;
                    end
                end
            end
            AISC_ARMED: begin
                if (edge_evt[0]) begin
                    next_st.fsm = AISC_RUN; // R1
                    ev[`AISC_INT_START] = 1'b1;
                end
            end
            AISC_RUN: begin
                if (stop) begin
                    next_st.fsm = AISC_IDLE; // R2
                    next_st.scan = 1'b0;
                    ev[`AISC_INT_END] = 1'b1;
                end
            end
            default: next_st.fsm = AISC_IDLE;
        endcase
        if (bus.wr && bus.addr == `AISC_OFF_CMD && bus.wdata[`AISC_CMD_STOP]
                && st.fsm != AISC_IDLE) begin
            next_st.fsm = AISC_IDLE; // R2
            next_st.scan = 1'b0;
            ev[`AISC_INT_END] = 1'b1;
        end

        // Register writes
        if (bus.wr) begin
            case (bus.addr)
                `AISC_OFF_CTRL: next_st.ctrl = bus.wdata[9:0];
                `AISC_OFF_INTERVAL: next_st.interval = bus.wdata;
                `AISC_OFF_COUNT: next_st.count_lim = bus.wdata;
                `AISC_OFF_CHAN: next_st.last_chan = bus.wdata[3:0];
                `AISC_OFF_INT_EN: next_st.int_en = bus.wdata[3:0];
                `AISC_OFF_INT_CLR: clr = bus.wdata[3:0];
                default: ;
            endcase
        end

        // Register reads
        if (bus.rd && aisc_mapped(bus.addr)) begin
            case (bus.addr)
                `AISC_OFF_CTRL: next_st.rdata = {22'h0, st.ctrl};
                `AISC_OFF_INTERVAL: next_st.rdata = st.interval;
                `AISC_OFF_COUNT: next_st.rdata = st.count_lim;
                `AISC_OFF_CHAN: next_st.rdata = {28'h0, st.last_chan};
                `AISC_OFF_STATUS: next_st.rdata = {17'h0, st.level, st.wait_done,
                    st.scan, st.fsm};
                `AISC_OFF_DATA: begin
                    if (st.level != 11'h0) begin
                        next_st.rdata = {16'h0, st.mem[st.rd_ptr]};
                        pop = 1'b1;
                    end
                end
                `AISC_OFF_INT_STAT: next_st.rdata = {28'h0, st.int_stat};
                `AISC_OFF_INT_EN: next_st.rdata = {28'h0, st.int_en};
                default: next_st.rdata = 32'h0;
            endcase
        end

        // Sample buffer
        if (push) begin
            next_st.mem[st.wr_ptr] = res.data; // R7
            next_st.wr_ptr = st.wr_ptr + 10'h1;
        end
        if (pop) begin
            next_st.rd_ptr = st.rd_ptr + 10'h1;
        end
        next_st.level = st.level + {10'h0, push} - {10'h0, pop};
        if (bus.wr && bus.addr == `AISC_OFF_CMD && bus.wdata[`AISC_CMD_CLEAR]) begin
            next_st.wr_ptr = 10'h0;
            next_st.rd_ptr = 10'h0;
            next_st.level = 11'h0;
        end

        // Interrupt: set wins over clear
        next_st.int_stat = (st.int_stat & ~clr) | ev; // R9
        next_st.irq = |(next_st.int_stat & next_st.int_en); // R9
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign conv = st.conv;
    assign irq = st.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    localparam int GAP_MIN = `AISC_CONV_CYC - 1;
    logic [11:0] gap;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gap <= 12'hfff;
        end else if (st.conv.start) begin
            gap <= 12'h0;
        end else if (gap != 12'hfff) begin
            gap <= gap + 12'h1;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    conv_spacing_a: assert property ( // R10
        st.conv.start |-> gap >= 12'(GAP_MIN))
        else $error("Conversions closer than the channel time");

    filt_commit_a: assert property ( // R4
        st.ctrl[`AISC_CTRL_FILT_LO] && $past(st.ctrl[`AISC_CTRL_FILT_LO])
            && $changed(st.filt[0]) |-> $past(st.fcnt[0]) == FILT_LAST)
        else $error("Filtered start input changed too early");

    stop_filt_a: assert property ( // R4
        st.ctrl[`AISC_CTRL_FILT_LO + 1] && $past(st.ctrl[`AISC_CTRL_FILT_LO + 1])
            && $changed(st.filt[1]) |-> $past(st.fcnt[1]) == FILT_LAST)
        else $error("Filtered stop input changed too early");

    edge_single_a: assert property ( // R13
        edge_evt[0] |=> !edge_evt[0])
        else $error("Start edge event longer than one cycle");

    sw_start_a: assert property ( // R1
        bus.wr && bus.addr == `AISC_OFF_CMD && bus.wdata[`AISC_CMD_START]
            && !bus.wdata[`AISC_CMD_STOP] && st.fsm == AISC_IDLE
            && !st.ctrl[`AISC_CTRL_START_SRC] |=> st.fsm == AISC_RUN)
        else $error("Software start did not run");

    count_stop_a: assert property ( // R2
        st.fsm == AISC_RUN && res.done && st.wait_done
            && st.ctrl[`AISC_CTRL_STOP_LO +: 2] == `AISC_STOP_COUNT
            && st.samples + 32'h1 == st.count_lim |=>
            st.fsm == AISC_IDLE && st.int_stat[`AISC_INT_END])
        else $error("Sample count did not stop");

    ext_pace_a: assert property ( // R5
        st.fsm == AISC_RUN && st.ctrl[`AISC_CTRL_PACE] && edge_evt[2] && !st.scan
            && !(bus.wr && bus.addr == `AISC_OFF_CMD) && !(res.done && st.wait_done)
            && !(st.ctrl[`AISC_CTRL_STOP_LO +: 2] == `AISC_STOP_EXT && edge_evt[1])
            |=> st.scan && st.chan == 4'h0)
        else $error("External clock edge did not start a scan");

    scan_issue_a: assert property ( // R8
        st.scan && !st.wait_done && st.space == 11'h0 |=>
            st.conv.start ##1 !st.conv.start[*2])
        else $error("Pending scan did not request a conversion");

    chan_range_a: assert property ( // R6
        st.conv.start |-> st.conv.chan <= st.last_chan)
        else $error("Channel beyond scan range");

    overrun_a: assert property ( // R12
        res.done && st.wait_done && st.level == DEPTH |=>
            st.int_stat[`AISC_INT_OVR] && st.wr_ptr == $past(st.wr_ptr))
        else $error("Full buffer not flagged or overwritten");

    irq_level_a: assert property ( // R9
        st.irq == |(st.int_stat & st.int_en))
        else $error("Interrupt does not follow enabled status");

    buf_bound_a: assert property ( // R7
        st.level <= DEPTH)
        else $error("Buffer level above capacity");

    sw_stop_a: assert property ( // R2
        bus.wr && bus.addr == `AISC_OFF_CMD && bus.wdata[`AISC_CMD_STOP]
            && st.fsm != AISC_IDLE |=> st.fsm == AISC_IDLE && !st.scan)
        else $error("Software stop did not end the run");

    ext_stop_a: assert property ( // R2
        st.fsm == AISC_RUN && st.ctrl[`AISC_CTRL_STOP_LO +: 2] == `AISC_STOP_EXT
            && edge_evt[1] |=> st.fsm == AISC_IDLE && st.int_stat[`AISC_INT_END])
        else $error("External stop edge did not end the run");

    armed_start_a: assert property ( // R1
        st.fsm == AISC_ARMED && edge_evt[0] && !(bus.wr && bus.addr == `AISC_OFF_CMD)
            |=> st.fsm == AISC_RUN && st.int_stat[`AISC_INT_START])
        else $error("Start edge did not begin the run");

    armed_hold_a: assert property ( // R1
        st.fsm == AISC_ARMED && !edge_evt[0] && !(bus.wr && bus.addr == `AISC_OFF_CMD)
            |=> st.fsm == AISC_ARMED)
        else $error("Armed state left without a start edge");

    clear_buf_a: assert property ( // R7
        bus.wr && bus.addr == `AISC_OFF_CMD && bus.wdata[`AISC_CMD_CLEAR]
            |=> st.level == 11'h0 && st.wr_ptr == st.rd_ptr)
        else $error("Buffer clear left samples behind");

endmodule // aisc_top

// ===== verification/aisc_conv_model.sv
// Converter model: answers each request after a short or a long delay
module aisc_conv_model (
    input wire logic mclk, // Clock
    input wire logic rst, // Async reset
    input wire aisc_pkg::aisc_conv_req_t conv, // Request from block
    output aisc_pkg::aisc_conv_res_t res, // Result to block
    output logic gap_bad // Requests too close or overlapping
);
    import aisc_pkg::*;
    int gap;
    int cnt;
    logic busy;
    logic slow;
    logic [3:0] ch;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            res <= '0;
            gap <= 2000;
            cnt <= 0;
            busy <= 1'b0;
            slow <= 1'b0;
            ch <= 4'h0;
            gap_bad <= 1'b0;
        end else begin
            gap <= gap + 1;
            res.done <= 1'b0;
            // Data is not valid outside done, so keep it moving
            res.data <= ~res.data;
            if (conv.start) begin
                if (gap < 2000 || busy) begin
                    gap_bad <= 1'b1;
                end
                gap <= 1;
                busy <= 1'b1;
                cnt <= slow ? 300 : 1;
                slow <= ~slow;
                ch <= conv.chan;
            end else if (busy) begin
                cnt <= cnt - 1;
                if (cnt == 1) begin
                    busy <= 1'b0;
                    res <= {1'b1, 12'h5a0, ch};
                end
            end
        end
    end
endmodule // aisc_conv_model

// ===== verification/analog_input_sampling_control_tb.sv
// Self-checking bench for the analog input sampling control block
module analog_input_sampling_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import aisc_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    aisc_bus_t bus = '0;
    logic [31:0] rdata;
    aisc_conv_res_t res;
    aisc_conv_req_t conv;
    logic ext_start = 1'b1;
    logic ext_stop = 1'b0;
    logic ext_clk = 1'b0;
    logic irq;
    logic gap_bad;
    logic [31:0] d;
    int n_errors = 0;
    int comparisons = 0;
    // Address, write data, expected read-back
    logic [71:0] rows [8] = '{
        {8'h00, 32'hffff_ffff, 32'h0000_03ff},
        {8'h08, 32'h1234_5678, 32'h1234_5678},
        {8'h0c, 32'h0000_0abc, 32'h0000_0abc},
        {8'h10, 32'hffff_fff5, 32'h0000_0005},
        {8'h20, 32'hffff_ffff, 32'h0000_000f},
        {8'h24, 32'h0000_000f, 32'h0000_0000},
        {8'h14, 32'hffff_ffff, 32'h0000_0000},
        {8'h28, 32'hffff_ffff, 32'h0000_0000}
    };

    always #2.5 mclk = ~mclk;

    aisc_top aisc_top_inst (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .res(res),
        .conv(conv), .ext_start(ext_start), .ext_stop(ext_stop), .ext_clk(ext_clk), .irq(irq));
    aisc_conv_model aisc_conv_model_inst (.mclk(mclk), .rst(rst), .conv(conv), .res(res),
        .gap_bad(gap_bad));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a, d);
        chk(d, e);
    endtask
    // Poll status until the masked bits match, bounded
    task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
        for (int i = 0; i < 4000; i++) begin
            rd(8'h14, d);
            if ((d & m) === v) return;
        end
        n_errors++;
        tally_and_finish();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        rc(8'h14, 32'h0);
        rc(8'h1c, 32'h0);
        chk({31'h0, irq}, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i][71:64], rows[i][63:32]);
            rc(rows[i][71:64], rows[i][31:0]);
        end
        // Software start, timer pace, count stop after three results
        wr(8'h00, 32'h0);
        wr(8'h08, 32'd100);
        wr(8'h0c, 32'd3);
        wr(8'h10, 32'h1);
        wr(8'h20, 32'h3);
        wr(8'h04, 32'h1);
        wait_st(32'h3, 32'h3);
        chk({31'h0, irq}, 32'h1);
        wait_st(32'h3, 32'h0);
        rd(8'h14, d);
        chk(d & 32'h7ff0, 32'h30);
        rc(8'h18, 32'h5a00);
        rc(8'h18, 32'h5a01);
        rc(8'h18, 32'h5a00);
        rc(8'h18, 32'h0);
        wr(8'h20, 32'h0);
        rc(8'h1c, 32'hb);
        chk({31'h0, irq}, 32'h0);
        wr(8'h24, 32'hf);
        wr(8'h20, 32'h3);
        rc(8'h1c, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // Armed external start on a filtered falling edge, external pacing
        wr(8'h00, 32'h9d);
        wr(8'h04, 32'h1);
        wait_st(32'h3, 32'h1);
        @(posedge mclk);
        ext_start <= 1'b0;
        repeat (50) @(posedge mclk);
        ext_start <= 1'b1;
        repeat (300) @(posedge mclk);
        rd(8'h14, d);
        chk(d & 32'h3, 32'h1);
        @(posedge mclk);
        ext_start <= 1'b0;
        wait_st(32'h3, 32'h3);
        @(posedge mclk);
        ext_start <= 1'b1;
        ext_clk <= 1'b1;
        wait_st(32'h7ffc, 32'h20);
        @(posedge mclk);
        ext_clk <= 1'b0;
        repeat (20) @(posedge mclk);
        rd(8'h14, d);
        chk(d & 32'h7ffc, 32'h20);
        wr(8'h04, 32'h2);
        wait_st(32'h3, 32'h0);
        rc(8'h18, 32'h5a00);
        rc(8'h18, 32'h5a01);
        // Software start, stop on a rising external stop edge
        wr(8'h00, 32'h2);
        wr(8'h08, 32'h0010_0000);
        wr(8'h04, 32'h1);
        wait_st(32'h3, 32'h3);
        @(posedge mclk);
        ext_stop <= 1'b1;
        wait_st(32'h3, 32'h0);
        // Filtered falling stop edge under timer pace, then buffer clear
        wr(8'h00, 32'h122);
        wr(8'h08, 32'd50);
        wr(8'h04, 32'h1);
        wait_st(32'h7ff3, 32'h13);
        @(posedge mclk);
        ext_stop <= 1'b0;
        repeat (50) @(posedge mclk);
        ext_stop <= 1'b1;
        repeat (300) @(posedge mclk);
        rd(8'h14, d);
        chk(d & 32'h3, 32'h3);
        @(posedge mclk);
        ext_stop <= 1'b0;
        wait_st(32'h3, 32'h0);
        wr(8'h04, 32'h4);
        rc(8'h18, 32'h0);
        rd(8'h14, d);
        chk(d & 32'h7ff0, 32'h0);
        chk({31'h0, gap_bad}, 32'h0);
        // Second reset returns the registers to zero
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rc(8'h00, 32'h0);
        chk({31'h0, irq}, 32'h0);
        tally_and_finish();
    end
endmodule // analog_input_sampling_control_tb
